//--- design/uart_defs.vh
/*
 * Constants for the dual serial port: register indexes, field
 * positions, reset values, mode codes and timing counts.
 * Assumes the includer uses 11-bit register indexes (byte address / 4).
 */
`ifndef UART_DEFS_VH
`define UART_DEFS_VH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_TIMER2_CONTROL     11'h418
`define IDX_TIMER2_MODE_SELECT     11'h419
`define IDX_SCON0     11'h420
`define IDX_BUF0      11'h421
`define IDX_STAT0     11'h422
`define IDX_SADR0     11'h423
`define IDX_SCON1     11'h424
`define IDX_BUF1      11'h425
`define IDX_STAT1     11'h426
`define IDX_SADR1     11'h427
`define IDX_SDEN0     11'h430
`define IDX_SDEN1     11'h431
`define IDX_T1REL     11'h438
`define IDX_T2REL     11'h439
`define IDX_SCR       11'h440

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SC_MPE        5
`define SC_REN        4
`define SC_TB8        3
`define SC_RB8        2
`define SC_TI         1
`define SC_RI         0
`define ST_FE         3
`define ST_BR         2
`define ST_OE         1
`define CK_RX         5
`define CK_TX         4
`define PT_HI         3
`define PT_LO         2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCON_RST      8'h00
`define STAT_RST      8'h00
`define SADR_RST      8'h00
`define SDEN_RST      8'h00
`define CTRL_RST      8'h00

// ----------------------------------------------------------------
// Modes, prescaler, frame lengths, sampling
// ----------------------------------------------------------------
`define MODE_SHIFT    2'b00
`define MODE_8BIT     2'b01
`define MODE_9FIX     2'b10
`define MODE_9VAR     2'b11
`define PRE_4         2'b00
`define PRE_16        2'b01
`define PRE_64        2'b10
`define PRE_END4      6'h03
`define PRE_END16     6'h0F
`define PRE_END64     6'h3F
`define LEN_SHIFT     4'h8
`define LEN_8BIT      4'hA
`define LEN_9BIT      4'hB
`define PH_SAMPLE     4'h8
`define PH_HALF       4'h8
`define PH_LAST       4'hF

// ----------------------------------------------------------------
// Interrupt vectors, by arbitration rank 7 to 10
// ----------------------------------------------------------------
`define VEC_RX0       8'hA0
`define VEC_TX0       8'hA4
`define VEC_RX1       8'hA8
`define VEC_TX1       8'hAC

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

`endif

//--- design/uart_dual.v
/*
 * Two serial ports with shift, 8-bit and 9-bit modes, address
 * matching, error flags and the baud timers, behind an AXI4-Lite
 * register slave. Assumes one 25 MHz clock that is also the
 * oscillator, a synchronous active-low reset and asynchronous
 * serial inputs.
 */
// Contract
// - Shift mode: data on input pin, clock out
// - 8-bit frame: start, 8 data, stop
// - 9-bit frame, ninth bit stored, osc/32
// - Mode 3 equals mode 2 but timer rate
// - Buffer write transmits, read gives receive register
// - Reception start conditions per mode
// - Internal clock sixteen times the baud rate
// - Prescaler codes divide by 4, 16, 64
// - Timer 1 default, select bits pick timer 2
// - Framing error flag on bad stop bit
// - Separate receive and transmit requests per port
// - Multiproc 9-bit: interrupt only when ninth set
// - Multiproc 8-bit needs valid stop bit
// - Address recognition gates receive-done flag
// - Given address is address under mask
// - Broadcast is address OR mask
// - Reset zeroes address and mask registers
// - Control register layout, resets to zero
`include "uart_defs.vh"

module uart_dual (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [12:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [12:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [1:0]  serial_in_pin,
	output wire [1:0]  serial_in_drive,
	output wire [1:0]  serial_in_oe_n,
	output wire [1:0]  serial_out_pin,
	output wire [3:0]  irq_req
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	// Mapped register check, shared by read and write paths
	function reg_hit;
		input [10:0] idx;
		begin
			case (idx)
			`IDX_TIMER2_CONTROL, `IDX_TIMER2_MODE_SELECT, `IDX_SCON0, `IDX_BUF0,
			`IDX_STAT0, `IDX_SADR0, `IDX_SCON1, `IDX_BUF1,
			`IDX_STAT1, `IDX_SADR1, `IDX_SDEN0, `IDX_SDEN1,
			`IDX_T1REL, `IDX_T2REL, `IDX_SCR: reg_hit = 1'b1;
			default: reg_hit = 1'b0;
			endcase
		end
	endfunction

	// Bits per frame for a mode, shared by both directions
	function [3:0] frame_len;
		input [1:0] mode;
		begin
			case (mode)
			`MODE_SHIFT: frame_len = `LEN_SHIFT;
			`MODE_8BIT:  frame_len = `LEN_8BIT;
			default:     frame_len = `LEN_9BIT;
			endcase
		end
	endfunction

	// Sixteen-times baud tick for one direction
	function tick_sel;
		input [1:0] mode;
		input       half;
		input       use_t2;
		input       t1;
		input       t2;
		begin
			case (mode)
			`MODE_SHIFT: tick_sel = 1'b1;
			`MODE_9FIX:  tick_sel = half;
			default:     tick_sel = use_t2 ? t2 : t1;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	wire        wr_fire = s_axi_awvalid & s_axi_wvalid &
			      s_axi_awready & s_axi_wready;
	wire        wr_lane = wr_fire & s_axi_wstrb[0];
	wire [10:0] wr_idx  = s_axi_awaddr[12:2];
	wire [7:0]  wd      = s_axi_wdata[7:0];
	wire        rd_fire = s_axi_arvalid & s_axi_arready;
	wire [10:0] rd_idx  = s_axi_araddr[12:2];
	wire [15:0] con_w;
	wire [15:0] buf_w;
	wire [15:0] stat_w;
	wire [15:0] sadr_w;
	wire [15:0] sden_w;
	reg  [7:0]  timer2_control_r;
	reg  [7:0]  timer2_mode_select_r;
	reg  [7:0]  scr_r;
	reg  [7:0]  t1rel_r;
	reg  [7:0]  t2rel_r;
	reg  [7:0]  rd_mux;

	// Address and data are taken together, one write at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			if (s_axi_awvalid & s_axi_wvalid & !s_axi_awready &
			    !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= reg_hit(wr_idx) ?
						`RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read data selection; unmapped reads return zero
	always @* begin
		case (rd_idx)
		`IDX_TIMER2_CONTROL: rd_mux = timer2_control_r;
		`IDX_TIMER2_MODE_SELECT: rd_mux = timer2_mode_select_r;
		`IDX_SCR:   rd_mux = scr_r;
		`IDX_T1REL: rd_mux = t1rel_r;
		`IDX_T2REL: rd_mux = t2rel_r;
		`IDX_SCON0: rd_mux = con_w[7:0];
		`IDX_BUF0:  rd_mux = buf_w[7:0];
		`IDX_STAT0: rd_mux = stat_w[7:0];
		`IDX_SADR0: rd_mux = sadr_w[7:0];
		`IDX_SDEN0: rd_mux = sden_w[7:0];
		`IDX_SCON1: rd_mux = con_w[15:8];
		`IDX_BUF1:  rd_mux = buf_w[15:8];
		`IDX_STAT1: rd_mux = stat_w[15:8];
		`IDX_SADR1: rd_mux = sadr_w[15:8];
		`IDX_SDEN1: rd_mux = sden_w[15:8];
		default:    rd_mux = 8'h00;
		endcase
	end

	// Read answer one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid & !s_axi_arready &
					 !s_axi_rvalid;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h00_0000, rd_mux};
				s_axi_rresp  <= reg_hit(rd_idx) ?
						`RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Shared control registers and baud timers
	// ------------------------------------------------------------
	reg  [5:0] pre_cnt_r;
	reg  [7:0] t1_cnt_r;
	reg  [7:0] t2_cnt_r;
	reg        t1_ovf_r;
	reg        t2_ovf_r;
	reg        half_r;
	reg  [5:0] pre_end;
	wire [1:0] pt = {scr_r[`PT_HI], scr_r[`PT_LO]};

	// Prescaler terminal count; the reserved code stops the timers
	always @* begin
		case (pt)
		`PRE_4:  pre_end = `PRE_END4;
		`PRE_16: pre_end = `PRE_END16;
		default: pre_end = `PRE_END64;
		endcase
	end

	wire pre_tick = (pt != 2'b11) & (pre_cnt_r >= pre_end);

	// Config writes, prescaler and auto-reload timers
	always @(posedge aclk) begin
		if (!aresetn) begin
			timer2_control_r   <= `CTRL_RST;
			timer2_mode_select_r   <= `CTRL_RST;
			scr_r     <= `CTRL_RST;
			t1rel_r   <= `CTRL_RST;
			t2rel_r   <= `CTRL_RST;
			pre_cnt_r <= 6'h00;
			t1_cnt_r  <= 8'h00;
			t2_cnt_r  <= 8'h00;
			t1_ovf_r  <= 1'b0;
			t2_ovf_r  <= 1'b0;
			half_r    <= 1'b0;
		end else begin
			if (wr_lane & wr_idx == `IDX_TIMER2_CONTROL) timer2_control_r <= wd;
			if (wr_lane & wr_idx == `IDX_TIMER2_MODE_SELECT) timer2_mode_select_r <= wd;
			if (wr_lane & wr_idx == `IDX_SCR)   scr_r   <= wd;
			if (wr_lane & wr_idx == `IDX_T1REL) t1rel_r <= wd;
			if (wr_lane & wr_idx == `IDX_T2REL) t2rel_r <= wd;
			half_r    <= ~half_r;
			pre_cnt_r <= pre_tick | (pre_cnt_r >= pre_end) ?
				     6'h00 : pre_cnt_r + 6'h01;
			t1_ovf_r  <= pre_tick & (&t1_cnt_r);
			t2_ovf_r  <= pre_tick & (&t2_cnt_r);
			if (pre_tick) begin
				t1_cnt_r <= (&t1_cnt_r) ? t1rel_r :
					    t1_cnt_r + 8'h01;
				t2_cnt_r <= (&t2_cnt_r) ? t2rel_r :
					    t2_cnt_r + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Serial port pair
	// ------------------------------------------------------------
	genvar g;
	generate
	for (g = 0; g < 2; g = g + 1) begin : port
		localparam [10:0] I_CON  = g ? `IDX_SCON1 : `IDX_SCON0;
		localparam [10:0] I_BUF  = g ? `IDX_BUF1  : `IDX_BUF0;
		localparam [10:0] I_STAT = g ? `IDX_STAT1 : `IDX_STAT0;
		localparam [10:0] I_SADR = g ? `IDX_SADR1 : `IDX_SADR0;
		localparam [10:0] I_SDEN = g ? `IDX_SDEN1 : `IDX_SDEN0;

		reg  [7:0]  con_r;
		reg  [7:0]  con_nxt;
		reg  [7:0]  stat_r;
		reg  [7:0]  stat_nxt;
		reg  [7:0]  rxbuf_r;
		reg  [7:0]  sadr_r;
		reg  [7:0]  sden_r;
		reg         unread_r;
		reg         s1_r;
		reg         s2_r;
		reg         s3_r;
		reg         tx_busy_r;
		reg  [10:0] tx_sh_r;
		reg  [3:0]  tx_cnt_r;
		reg  [3:0]  tx_ph_r;
		reg         ti_set_r;
		reg         rx_busy_r;
		reg  [10:0] rx_bits_r;
		reg  [3:0]  rx_cnt_r;
		reg  [3:0]  rx_ph_r;
		reg         rx_done_r;
		reg         out_r;
		reg         drv_r;
		reg         oe_n_r;

		wire [1:0] mode = con_r[7:6];
		wire       nine = mode[1];
		wire [3:0] len  = frame_len(mode);
		wire       tx_tick = tick_sel(mode, half_r,
			g ? timer2_mode_select_r[`CK_TX] : timer2_control_r[`CK_TX],
			t1_ovf_r, t2_ovf_r);
		wire       rx_tick = tick_sel(mode, half_r,
			g ? timer2_mode_select_r[`CK_RX] : timer2_control_r[`CK_RX],
			t1_ovf_r, t2_ovf_r);
		wire       wr_buf = wr_lane & wr_idx == I_BUF;

		// Received frame decode
		wire [7:0] rx_data = (mode == `MODE_SHIFT) ?
				     rx_bits_r[7:0] : rx_bits_r[8:1];
		wire       ninth = rx_bits_r[9];
		wire       stop  = (mode == `MODE_8BIT) ?
				   rx_bits_r[9] : rx_bits_r[10];
		wire       g_hit = ((rx_data ^ sadr_r) & sden_r) == 8'h00;
		wire       b_hit = &(rx_data | ~(sadr_r | sden_r));
		wire       accept = (mode == `MODE_SHIFT) |
				    !con_r[`SC_MPE] |
				    (nine ? (ninth & (g_hit | b_hit)) :
				     stop);
		wire       acc = rx_done_r & accept;
		wire       async_end = rx_done_r & (mode != `MODE_SHIFT);
		wire       rx_start = !rx_busy_r & con_r[`SC_REN] &
			((mode == `MODE_SHIFT) ? (!con_r[`SC_RI] &
			  !tx_busy_r) : (s3_r & !s2_r));

		// Control and status next values; hardware sets win
		always @* begin
			con_nxt  = (wr_lane & wr_idx == I_CON) ? wd : con_r;
			stat_nxt = (wr_lane & wr_idx == I_STAT) ? wd : stat_r;
			if (ti_set_r)
				con_nxt[`SC_TI] = 1'b1;
			if (acc) begin
				con_nxt[`SC_RI] = 1'b1;
				if (nine)
					con_nxt[`SC_RB8] = ninth;
				else if (mode == `MODE_8BIT)
					con_nxt[`SC_RB8] = stop;
				if (unread_r)
					stat_nxt[`ST_OE] = 1'b1;
			end
			if (async_end & !stop)
				stat_nxt[`ST_FE] = 1'b1;
			if (async_end & !stop & rx_data == 8'h00 &
			    !(nine & ninth))
				stat_nxt[`ST_BR] = 1'b1;
		end

		// Registers of this port
		always @(posedge aclk) begin
			if (!aresetn) begin
				con_r    <= `SCON_RST;
				stat_r   <= `STAT_RST;
				sadr_r   <= `SADR_RST;
				sden_r   <= `SDEN_RST;
				rxbuf_r  <= 8'h00;
				unread_r <= 1'b0;
				s1_r     <= 1'b1;
				s2_r     <= 1'b1;
				s3_r     <= 1'b1;
			end else begin
				con_r  <= con_nxt;
				stat_r <= stat_nxt;
				if (wr_lane & wr_idx == I_SADR) sadr_r <= wd;
				if (wr_lane & wr_idx == I_SDEN) sden_r <= wd;
				if (acc)
					rxbuf_r <= rx_data;
				// A new character marks unread even if read now
				if (acc)
					unread_r <= 1'b1;
				else if (rd_fire & rd_idx == I_BUF)
					unread_r <= 1'b0;
				s1_r <= serial_in_pin[g];
				s2_r <= s1_r;
				s3_r <= s2_r;
			end
		end

		// Transmitter; a buffer write restarts any frame in flight
		always @(posedge aclk) begin
			if (!aresetn) begin
				tx_busy_r <= 1'b0;
				tx_sh_r   <= 11'h7FF;
				tx_cnt_r  <= 4'h0;
				tx_ph_r   <= 4'h0;
				ti_set_r  <= 1'b0;
			end else begin
				ti_set_r <= 1'b0;
				if (wr_buf) begin
					tx_busy_r <= 1'b1;
					tx_cnt_r  <= 4'h0;
					tx_ph_r   <= 4'h0;
					case (mode)
					`MODE_SHIFT: tx_sh_r <= {3'b111, wd};
					`MODE_8BIT:  tx_sh_r <= {2'b11, wd,
								 1'b0};
					default: tx_sh_r <= {1'b1,
						con_r[`SC_TB8], wd, 1'b0};
					endcase
				end else if (tx_busy_r & tx_tick) begin
					tx_ph_r <= tx_ph_r + 4'h1;
					if (tx_ph_r == `PH_LAST) begin
						tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
						tx_cnt_r <= tx_cnt_r + 4'h1;
						if (tx_cnt_r == len - 4'h1) begin
							tx_busy_r <= 1'b0;
							ti_set_r  <= 1'b1;
						end
					end
				end
			end
		end

		// Receiver: mid-bit sample, false starts dropped
		always @(posedge aclk) begin
			if (!aresetn) begin
				rx_busy_r <= 1'b0;
				rx_bits_r <= 11'h000;
				rx_cnt_r  <= 4'h0;
				rx_ph_r   <= 4'h0;
				rx_done_r <= 1'b0;
			end else begin
				rx_done_r <= 1'b0;
				if (rx_start) begin
					rx_busy_r <= 1'b1;
					rx_cnt_r  <= 4'h0;
					rx_ph_r   <= 4'h0;
				end else if (rx_busy_r & rx_tick) begin
					rx_ph_r <= rx_ph_r + 4'h1;
					if (rx_ph_r == `PH_SAMPLE) begin
						rx_bits_r[rx_cnt_r] <= s2_r;
						if (rx_cnt_r == 4'h0 & s2_r &
						    mode != `MODE_SHIFT)
							rx_busy_r <= 1'b0;
					end
					if (rx_ph_r == `PH_LAST) begin
						rx_cnt_r <= rx_cnt_r + 4'h1;
						if (rx_cnt_r == len - 4'h1) begin
							rx_busy_r <= 1'b0;
							rx_done_r <= 1'b1;
						end
					end
				end
			end
		end

		// Pins: shift mode drives data on the input pin
		// and a clock, low for the first half bit, on the output
		always @(posedge aclk) begin
			if (!aresetn) begin
				out_r  <= 1'b1;
				drv_r  <= 1'b1;
				oe_n_r <= 1'b1;
			end else if (mode == `MODE_SHIFT) begin
				out_r  <= tx_busy_r ? tx_ph_r >= `PH_HALF :
					  rx_busy_r ? rx_ph_r >= `PH_HALF :
					  1'b1;
				drv_r  <= tx_sh_r[0];
				oe_n_r <= !tx_busy_r;
			end else begin
				out_r  <= tx_busy_r ? tx_sh_r[0] : 1'b1;
				drv_r  <= 1'b1;
				oe_n_r <= 1'b1;
			end
		end

		assign serial_out_pin[g]  = out_r;
		assign serial_in_drive[g] = drv_r;
		assign serial_in_oe_n[g]  = oe_n_r;
		assign irq_req[2*g]       = con_r[`SC_RI];
		assign irq_req[2*g+1]     = con_r[`SC_TI];
		assign con_w[8*g+7:8*g]   = con_r;
		assign buf_w[8*g+7:8*g]   = rxbuf_r;
		assign stat_w[8*g+7:8*g]  = stat_r;
		assign sadr_w[8*g+7:8*g]  = sadr_r;
		assign sden_w[8*g+7:8*g]  = sden_r;
	end
	endgenerate

endmodule // uart_dual

//--- dv/uart_dual_properties.sv
/*
 * Checker for the dual serial port: bus handshakes, done flags, pins.
 * Assumes it is bound to uart_dual and sees only its ports.
 */
module uart_dual_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [1:0]  serial_out_pin,
	input wire logic [3:0]  irq_req
);
	// ----------------------------------------------------------------
	// Properties, all in the one clock domain
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	aw_w_pair_a: assert property (s_axi_awready |-> s_axi_wready)
		else $error("write ready signals split");
	write_take_a: assert property (s_axi_awvalid && s_axi_wvalid &&
		!s_axi_awready && !s_axi_bvalid |=> s_axi_awready)
		else $error("write not taken");
	write_resp_a: assert property (s_axi_awready |=> s_axi_bvalid)
		else $error("write response late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	read_take_a: assert property (s_axi_arvalid && !s_axi_arready &&
		!s_axi_rvalid |=> s_axi_arready)
		else $error("read not taken");
	read_resp_a: assert property (s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	// Only a software write may take a done flag down
	flag_clear_a: assert property (|(~irq_req & $past(irq_req))
		|-> $past(s_axi_awready))
		else $error("done flag cleared by hardware");
	// Shortest low phase is half a shift-clock bit of 16 clocks
	start_len_a: assert property ($fell(serial_out_pin[0])
		|-> !serial_out_pin[0] [*8])
		else $error("line low phase too short");

	cover property (s_axi_bvalid && s_axi_bready);
	cover property ($rose(irq_req[0]));
	cover property ($rose(irq_req[1]));
endmodule // uart_dual_checker

bind uart_dual uart_dual_checker u_uart_dual_checker (
	.aclk          (aclk),
	.aresetn       (aresetn),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_wvalid  (s_axi_wvalid),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bresp   (s_axi_bresp),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rdata   (s_axi_rdata),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready),
	.serial_out_pin(serial_out_pin),
	.irq_req       (irq_req)
);

//--- dv/uart_peer.sv
/*
 * Remote serial peer: sends and captures frames LSB first.
 * Assumes the bench sets bit_clks to the bit time in clocks.
 */
module uart_peer (
	input  wire logic aclk,
	input  wire logic rx_line,
	output logic      tx_line
);
	timeunit 1ns;
	timeprecision 1ps;
	int bit_clks = 32;

	// Idle line stays high between frames
	initial tx_line = 1'b1;

	task automatic send(input logic [10:0] frm, input int n);
		for (int i = 0; i < n; i++) begin
			tx_line <= frm[i];
			repeat (bit_clks) @(posedge aclk);
		end
		tx_line <= 1'b1;
	endtask

	// Bounded hunt for a start edge, then sample mid-bit
	task automatic recv(output logic [10:0] frm, input int n,
		output logic ok);
		int t;
		frm = '0;
		ok = 1'b0;
		for (t = 0; t < 20000 && rx_line; t++)
			@(posedge aclk);
		if (!rx_line) begin
			repeat (bit_clks / 2) @(posedge aclk);
			for (int i = 0; i < n; i++) begin
				frm[i] = rx_line;
				repeat (bit_clks) @(posedge aclk);
			end
			ok = 1'b1;
		end
	endtask
endmodule // uart_peer

//--- dv/uart_dual_bench.sv
/*
 * Bench for uart_dual: register tasks over AXI4-Lite, a peer on port 0.
 * Assumes uart_defs.vh is on the include path.
 */
`include "uart_defs.vh"
module uart_dual_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [12:0] awaddr = '0;
	logic [12:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0]  wstrb = 4'hF;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, peer_tx;
	logic [1:0]  bresp, rresp, drv, oe_n, sout, resp;
	logic [31:0] rdata;
	logic [3:0]  irq;
	wire logic [1:0] sin;
	int          bad_count = 0;
	int          n_checks = 0;
	logic [1:0]  md [5] = '{2'h2, 2'h3, 2'h1, 2'h1, 2'h1};
	logic [7:0]  sc [5] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h08};
	logic [7:0]  t2 [5] = '{8'h00, 8'h30, 8'h00, 8'h00, 8'h00};
	int          bc [5] = '{32, 128, 64, 256, 1024};
	logic [7:0]  mb [5] = '{8'h37, 8'hC2, 8'hC1, 8'hC2, 8'hFF};

	// Wire level: the port drives its input pin only in shift mode
	assign sin[0] = oe_n[0] ? peer_tx : drv[0];
	assign sin[1] = oe_n[1] ? 1'b1 : drv[1];
	always #20 aclk = ~aclk;

	uart_dual u_uart_dual (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.serial_in_pin(sin), .serial_in_drive(drv),
		.serial_in_oe_n(oe_n), .serial_out_pin(sout), .irq_req(irq));
	uart_peer peer (.aclk(aclk), .rx_line(sout[0]), .tx_line(peer_tx));

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic stall(input string nm);
		chk(nm, 32'h0000_0000, 32'h0000_0001);
		complete_run();
	endtask

	// Each channel is released at the edge where it is taken
	task automatic wr(input logic [10:0] ix, input logic [7:0] d);
		int t;
		@(posedge aclk);
		awaddr <= {ix, 2'b00};
		wdata <= 32'(d);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (t = 0; t < 64; t++) begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		bready <= 1'b0;
		resp = bresp;
		if (t == 64)
			stall("write wait");
	endtask
	task automatic rdc(input logic [10:0] ix, input logic [7:0] e);
		int t;
		@(posedge aclk);
		araddr <= {ix, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (t = 0; t < 64; t++) begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		rready <= 1'b0;
		resp = rresp;
		if (t == 64)
			stall("read wait");
		chk($sformatf("reg %h", ix), rdata, 32'(e));
	endtask

	initial begin
		logic [10:0] f;
		logic [7:0]  d;
		logic        ok;
		int          k;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		// --------------------------------------------------------
		// Reset values and an unmapped place
		// --------------------------------------------------------
		rdc(`IDX_SCON0, `SCON_RST);
		rdc(`IDX_SADR0, `SADR_RST);
		rdc(`IDX_SDEN0, `SDEN_RST);
		rdc(`IDX_STAT0, `STAT_RST);
		rdc(11'h7FF, 8'h00);
		chk("rresp", resp, `RESP_SLVERR);
		wr(11'h7FF, 8'h11);
		chk("bresp", resp, `RESP_SLVERR);
		wstrb <= 4'h0;
		wr(`IDX_SADR0, 8'h55);
		chk("strobe resp", resp, `RESP_OKAY);
		wstrb <= 4'hF;
		rdc(`IDX_SADR0, `SADR_RST);
		wr(`IDX_T1REL, 8'hFF);
		wr(`IDX_T2REL, 8'hFE);
		// Timers reload only on a wrap; let both wrap once first
		repeat (1100) @(posedge aclk);
		// Every async mode, clock source and prescale code both ways
		for (k = 0; k < 5; k++) begin
			peer.bit_clks = bc[k];
			d = 8'hA5 ^ 8'(k);
			wr(`IDX_SCR, sc[k]);
			wr(`IDX_TIMER2_CONTROL, t2[k]);
			wr(`IDX_SCON0, {md[k], 6'h08});
			wr(`IDX_BUF0, d);
			peer.recv(f, (md[k] == 2'h1) ? 10 : 11, ok);
			if (!ok)
				stall("frame wait");
			chk("frame", f, {md[k] != 2'h1, 1'b1, d, 1'b0});
			repeat (bc[k] / 8 + 20) @(posedge aclk);
			chk("tx done", irq, 4'h2);
			wr(`IDX_SCON0, {md[k], 6'h10});
			peer.send({1'b1, md[k] == 2'h1, ~d, 1'b0}, (md[k] == 2'h1) ? 10 : 11);
			repeat (bc[k] / 8 + 20) @(posedge aclk);
			chk("rx done", irq, 4'h1);
			rdc(`IDX_BUF0, ~d);
			rdc(`IDX_SCON0, {md[k], 3'b010, md[k] == 2'h1, 2'b01});
			wr(`IDX_SCON0, 8'h00);
		end
		// Multiproc in 8-bit mode withholds a frame with a bad stop
		peer.bit_clks = 64;
		wr(`IDX_SCR, 8'h00);
		wr(`IDX_SCON0, 8'h70);
		peer.send(11'h0AA, 10);
		repeat (30) @(posedge aclk);
		chk("stop gate", irq[0], 1'b0);
		// Receive gate, then break, framing and overrun
		peer.bit_clks = 32;
		wr(`IDX_SCON0, 8'h80);
		peer.send(11'h000, 11);
		repeat (30) @(posedge aclk);
		chk("rx off", irq, 4'h0);
		wr(`IDX_SCON0, 8'h90);
		peer.send(11'h000, 11);
		repeat (30) @(posedge aclk);
		wr(`IDX_SCON0, 8'h90);
		peer.send(11'h4AA, 11);
		repeat (30) @(posedge aclk);
		rdc(`IDX_STAT0, 8'h0E);
		wr(`IDX_STAT0, 8'h00);
		rdc(`IDX_STAT0, 8'h00);
		// Ninth-bit gate, given and broadcast address
		for (k = 0; k < 5; k++) begin
			if (k == 1) begin
				wr(`IDX_SADR0, 8'hC0);
				wr(`IDX_SDEN0, 8'hFD);
			end
			wr(`IDX_SCON0, 8'hB0);
			peer.send({1'b1, ((5'h17 >> k) & 5'h01) != 5'h00, mb[k], 1'b0}, 11);
			repeat (30) @(posedge aclk);
			chk("match", irq[0], (5'h13 >> k) & 5'h01);
		end
		// Shift mode on port 1: data taken at each rising clock
		wr(`IDX_BUF1, 8'h5C);
		f = '0;
		ok = 1'b1;
		k = 0;
		for (int t = 0; t < 400 && k < 8; t++) begin
			@(negedge aclk);
			if (sout[1] && !ok) begin
				f[k] = sin[1];
				k++;
			end
			ok = sout[1];
		end
		repeat (20) @(posedge aclk);
		chk("shift out", f, 11'h05C);
		chk("shift done", irq[3:2], 2'b10);
		chk("shift release", oe_n, 2'b11);
		wr(`IDX_SCON1, 8'h10);
		repeat (160) @(posedge aclk);
		chk("shift in done", irq[3:2], 2'b01);
		rdc(`IDX_BUF1, 8'hFF);
		complete_run();
	end
endmodule // uart_dual_bench
